// ---- include/aem_pkg.sv ----
// Overview of operation
// - Duty input break alarms unless disabled
// - Run time above threshold raises alarm
// - Comm timeout cleared by valid setpoint write
// - Reset by key, comm command, or input
// - Level two alarms keep output running
// - Burnout after too many consecutive exceeding cycles
// - One reset clears all level two alarms
// - Setpoint input out of span raises alarm
// - Startup run time checksum mismatch raises error
// - Settings area checksum failure raises error
// - System area checksum failure raises error
// - Working memory self check failure raises error
// - Long level press enters level, restarts
// - Up press selects initialise choice, shown
// - Enter restores defaults, returns after delay
// - Run time reset zeroes counter
// - Restart request performs full reset
// - Zero timeout setting disables timeout detection
package aem_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned LONG_PRESS_MS = 2000;
    localparam int unsigned RETURN_DELAY_MS = 500;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned LONG_PRESS_CYCLES = CLK_HZ / 1000 * LONG_PRESS_MS;
    localparam int unsigned RETURN_DELAY_CYCLES = CLK_HZ / 1000 * RETURN_DELAY_MS;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TMR_W = 26;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BURN_COUNT = 8'h04;
    localparam logic [7:0] OFS_RT_THRESH = 8'h08;
    localparam logic [7:0] OFS_COMM_TMO = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RUNTIME = 8'h14;
    localparam logic [7:0] OFS_SETPOINT = 8'h18;

    // Control register fields, setpoint limit and register reset values
    localparam int CTRL_DUTY_EN = 0;
    localparam int CTRL_COMM_VARIANT = 1;
    localparam int CTRL_RESET_CMD = 2;
    localparam logic [1:0] CTRL_RESET_VAL = 2'h1;
    localparam logic [15:0] SETPOINT_MAX = 16'h03E8;
    localparam logic [7:0] BURN_COUNT_RST = 8'h03;
    localparam logic [31:0] RT_THRESH_RST = 32'hFFFFFFFF;

    // Alarm flag positions
    localparam int NUM_ALARMS = 9;
    localparam int AL_RAM = 0;
    localparam int AL_SYS = 1;
    localparam int AL_SET = 2;
    localparam int AL_RTCHK = 3;
    localparam int AL_BURN = 4;
    localparam int AL_RANGE = 5;
    localparam int AL_DUTY = 6;
    localparam int AL_RUNTIME = 7;
    localparam int AL_COMM = 8;
    localparam logic [8:0] LEVEL2_MASK = 9'h0F0;

    // Display codes of each alarm
    localparam logic [7:0] ram_fault_code = 8'h01;
    localparam logic [7:0] system_checksum_code = 8'h02;
    localparam logic [7:0] settings_checksum_code = 8'h03;
    localparam logic [7:0] runtime_checksum_code = 8'h04;
    localparam logic [7:0] burnout_alarm_code = 8'h40;
    localparam logic [7:0] input_range_alarm_code = 8'h50;
    localparam logic [7:0] duty_input_alarm_code = 8'h51;
    localparam logic [7:0] runtime_alarm_code = 8'h60;
    localparam logic [7:0] comm_timeout_alarm_code = 8'h70;
    localparam logic [7:0] NO_ALARM_CODE = 8'h00;

    // Menu item shown on the display
    localparam logic [1:0] SHOW_RUN = 2'h0;
    localparam logic [1:0] SHOW_PARAM = 2'h1;
    localparam logic [1:0] SHOW_MENU = 2'h2;
    localparam logic [1:0] SHOW_CHOICE = 2'h3;

    typedef enum logic [2:0] {
        MENU_RUN, MENU_LEVEL, MENU_ENTERED, MENU_CHOICE, MENU_RETURN
    } aem_menu_e;

    // Pin inputs after synchronising
    typedef struct packed {
        logic enter_key;
        logic level_key;
        logic up_key;
        logic reset_in;
        logic burn_exceed;
        logic line_cycle;
        logic range_fault;
        logic duty_open;
        logic ram_fault;
        logic nv_sys_bad;
        logic nv_set_bad;
        logic nv_rt_bad;
    } aem_pins_s;
endpackage : aem_pkg

// ---- src/aem_alarm_manager.sv ----
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module aem_alarm_manager import aem_pkg::*; #(
    parameter int unsigned LONG_CYC = LONG_PRESS_CYCLES,
    parameter int unsigned RETURN_CYC = RETURN_DELAY_CYCLES,
    parameter int unsigned TICK_CYC = TICK_CYCLES
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Front panel and reset pins
    input wire logic I_ENTER_CLEAR_KEY,
    input wire logic I_LEVEL_SELECT_KEY,
    input wire logic I_UP_KEY,
    input wire logic I_RESET_INPUT,
    // Fault detector pins
    input wire logic I_BURN_EXCEED,
    input wire logic I_LINE_CYCLE,
    input wire logic I_RANGE_FAULT,
    input wire logic I_DUTY_OPEN,
    input wire logic I_RAM_FAULT,
    input wire logic I_NV_SYS_BAD,
    input wire logic I_NV_SET_BAD,
    input wire logic I_NV_RT_BAD,
    // Outputs to power stage and display
    output logic O_OUTPUT_ENABLE,
    output logic [7:0] O_ERROR_CODE,
    output logic [1:0] O_DISPLAY_ITEM,
    output logic O_SELECT_RUNTIME,
    output logic O_LOAD_DEFAULTS,
    output logic O_RESTART
);
    // Two flop synchroniser; stage one is read only by stage two
    aem_pins_s pin_s1, pin_s2, pin_d;
    always_ff @(posedge I_REF_CLK) begin
        pin_s1 <= {I_ENTER_CLEAR_KEY, I_LEVEL_SELECT_KEY, I_UP_KEY, I_RESET_INPUT, I_BURN_EXCEED,
                   I_LINE_CYCLE, I_RANGE_FAULT, I_DUTY_OPEN, I_RAM_FAULT, I_NV_SYS_BAD,
                   I_NV_SET_BAD, I_NV_RT_BAD};
        pin_s2 <= pin_s1;
        pin_d <= pin_s2;
    end
    aem_pins_s rise;
    assign rise = pin_s2 & ~pin_d;

    // Register state
    logic duty_input_enable_param, communicating_variant;
    logic [7:0] burnout_count_param;
    logic [31:0] runtime_threshold_param;
    logic [15:0] comm_timeout_param;
    logic [31:0] runtime, prdata;
    logic [8:0] alarms;
    aem_menu_e menu;
    logic [1:0] next_ctrl;
    logic [7:0] next_burn_cnt_p;
    logic [31:0] next_rt_thr;
    logic [15:0] next_tmo;
    logic [31:0] next_prdata;
    logic wr, rd, mapped, reset_cmd, setpoint_ok;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd = I_PSEL && !I_PENABLE && !I_PWRITE;
    assign mapped = hit(I_PADDR, OFS_CTRL) || hit(I_PADDR, OFS_BURN_COUNT) || hit(I_PADDR, OFS_RT_THRESH)
        || hit(I_PADDR, OFS_COMM_TMO) || hit(I_PADDR, OFS_STATUS) || hit(I_PADDR, OFS_RUNTIME)
        || hit(I_PADDR, OFS_SETPOINT);
    // Reset command only honoured on the communicating variant
    assign reset_cmd = wr && hit(I_PADDR, OFS_CTRL) && I_PWDATA[CTRL_RESET_CMD] && communicating_variant;
    assign setpoint_ok = wr && hit(I_PADDR, OFS_SETPOINT) && (I_PWDATA[15:0] <= SETPOINT_MAX);
    // Never stalls; unmapped addresses answer with an error
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
    assign O_PRDATA = prdata;

    // Register writes in the access phase, read capture in the setup phase
    always_comb begin
        next_ctrl = {communicating_variant, duty_input_enable_param};
        next_burn_cnt_p = burnout_count_param;
        next_rt_thr = runtime_threshold_param;
        next_tmo = comm_timeout_param;
        next_prdata = prdata;
        if (wr && hit(I_PADDR, OFS_CTRL)) begin
            next_ctrl = {I_PWDATA[CTRL_COMM_VARIANT], I_PWDATA[CTRL_DUTY_EN]};
        end
        if (wr && hit(I_PADDR, OFS_BURN_COUNT)) begin
            next_burn_cnt_p = I_PWDATA[7:0];
        end
        if (wr && hit(I_PADDR, OFS_RT_THRESH)) begin
            next_rt_thr = I_PWDATA;
        end
        if (wr && hit(I_PADDR, OFS_COMM_TMO)) begin
            next_tmo = I_PWDATA[15:0];
        end
        if (rd) begin
            case (I_PADDR)
                OFS_CTRL: next_prdata = {30'h0, communicating_variant, duty_input_enable_param};
                OFS_BURN_COUNT: next_prdata = {24'h0, burnout_count_param};
                OFS_RT_THRESH: next_prdata = runtime_threshold_param;
                OFS_COMM_TMO: next_prdata = {16'h0, comm_timeout_param};
                OFS_STATUS: next_prdata = {14'h0, O_ERROR_CODE, O_OUTPUT_ENABLE, alarms};
                OFS_RUNTIME: next_prdata = runtime;
                default: next_prdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            {communicating_variant, duty_input_enable_param} <= CTRL_RESET_VAL;
            burnout_count_param <= BURN_COUNT_RST;
            runtime_threshold_param <= RT_THRESH_RST;
            comm_timeout_param <= 16'h0;
            prdata <= 32'h0;
        end else begin
            {communicating_variant, duty_input_enable_param} <= next_ctrl;
            burnout_count_param <= next_burn_cnt_p;
            runtime_threshold_param <= next_rt_thr;
            comm_timeout_param <= next_tmo;
            prdata <= next_prdata;
        end
    end

    // Millisecond tick, run time, burnout run length and comm silence counters
    logic [TMR_W-1:0] tick_cnt, next_tick_cnt;
    logic [7:0] burn_run, next_burn_run;
    logic [15:0] silence, next_silence;
    logic [31:0] next_runtime;
    logic tick, rt_clear;
    assign tick = (tick_cnt == TMR_W'(TICK_CYC - 1));
    always_comb begin
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
        next_runtime = runtime;
        if (rt_clear) begin
            next_runtime = 32'h0;
        end else if (tick && runtime != 32'hFFFFFFFF) begin
            next_runtime = runtime + 1'b1;
        end
        next_burn_run = burn_run;
        if (rise.line_cycle) begin
            next_burn_run = !pin_s2.burn_exceed ? 8'h0 : (burn_run == 8'hFF ? burn_run : burn_run + 1'b1);
        end
        next_silence = silence;
        if (I_PSEL && I_PENABLE) begin
            next_silence = 16'h0;
        end else if (tick && silence != 16'hFFFF) begin
            next_silence = silence + 1'b1;
        end
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            tick_cnt <= '0;
            runtime <= 32'h0;
            burn_run <= 8'h0;
            silence <= 16'h0;
        end else begin
            tick_cnt <= next_tick_cnt;
            runtime <= next_runtime;
            burn_run <= next_burn_run;
            silence <= next_silence;
        end
    end

    // Alarm set and clear; a set in the clearing cycle wins
    logic [8:0] cause, clear_mask, next_alarms;
    logic alarm_reset;
    assign alarm_reset = rise.enter_key && menu == MENU_RUN || reset_cmd || rise.reset_in;
    always_comb begin
        cause = '0;
        cause[AL_RAM] = pin_s2.ram_fault;
        cause[AL_SYS] = pin_s2.nv_sys_bad;
        cause[AL_SET] = pin_s2.nv_set_bad;
        cause[AL_RTCHK] = pin_s2.nv_rt_bad;
        cause[AL_BURN] = burn_run > burnout_count_param;
        cause[AL_RANGE] = pin_s2.range_fault;
        cause[AL_DUTY] = pin_s2.duty_open && duty_input_enable_param;
        cause[AL_RUNTIME] = runtime > runtime_threshold_param;
        cause[AL_COMM] = comm_timeout_param != 16'h0 && silence >= comm_timeout_param;
        clear_mask = alarm_reset ? LEVEL2_MASK : '0;
        clear_mask[AL_COMM] = setpoint_ok;
        next_alarms = (alarms & ~clear_mask) | cause;
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            alarms <= '0;
        end else begin
            alarms <= next_alarms;
        end
    end

    // Output gating and highest priority display code
    logic [7:0] next_code;
    logic next_out_en;
    always_comb begin
        next_out_en = (alarms & ~LEVEL2_MASK) == '0;
        next_code = NO_ALARM_CODE;
        if (alarms[AL_RAM]) next_code = ram_fault_code;
        else if (alarms[AL_SYS]) next_code = system_checksum_code;
        else if (alarms[AL_SET]) next_code = settings_checksum_code;
        else if (alarms[AL_RTCHK]) next_code = runtime_checksum_code;
        else if (alarms[AL_COMM]) next_code = comm_timeout_alarm_code;
        else if (alarms[AL_BURN]) next_code = burnout_alarm_code;
        else if (alarms[AL_RANGE]) next_code = input_range_alarm_code;
        else if (alarms[AL_DUTY]) next_code = duty_input_alarm_code;
        else if (alarms[AL_RUNTIME]) next_code = runtime_alarm_code;
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_OUTPUT_ENABLE <= 1'b0;
            O_ERROR_CODE <= NO_ALARM_CODE;
        end else begin
            O_OUTPUT_ENABLE <= next_out_en;
            O_ERROR_CODE <= next_code;
        end
    end

    // Key menu; a long press fires once per hold
    aem_menu_e next_menu;
    logic [TMR_W-1:0] hold, next_hold, wait_cnt, next_wait;
    logic fired, next_fired, sel_rt, next_sel_rt, long_press, next_defaults, next_restart;
    assign long_press = pin_s2.level_key && !fired && hold == TMR_W'(LONG_CYC - 1);
    always_comb begin
        next_menu = menu;
        next_sel_rt = sel_rt;
        next_wait = wait_cnt;
        next_defaults = 1'b0;
        next_restart = 1'b0;
        rt_clear = 1'b0;
        next_hold = pin_s2.level_key && !fired ? hold + 1'b1 : '0;
        next_fired = pin_s2.level_key && (fired || long_press);
        case (menu)
            MENU_RUN: if (long_press) next_menu = MENU_LEVEL;
            MENU_LEVEL: begin
                if (long_press) begin
                    next_restart = 1'b1;
                    next_menu = MENU_RUN;
                end else if (rise.enter_key) next_menu = MENU_ENTERED;
                else if (rise.up_key) next_sel_rt = !sel_rt;
            end
            MENU_ENTERED: if (rise.up_key) next_menu = MENU_CHOICE;
            MENU_CHOICE: begin
                if (rise.enter_key) begin
                    next_defaults = !sel_rt;
                    rt_clear = sel_rt;
                    next_wait = TMR_W'(RETURN_CYC - 1);
                    next_menu = MENU_RETURN;
                end
            end
            MENU_RETURN: begin
                next_wait = wait_cnt - 1'b1;
                if (wait_cnt == '0) next_menu = MENU_LEVEL;
            end
            default: next_menu = MENU_RUN;
        endcase
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            menu <= MENU_RUN;
            hold <= '0;
            fired <= 1'b0;
            sel_rt <= 1'b0;
            wait_cnt <= '0;
            O_LOAD_DEFAULTS <= 1'b0;
            O_RESTART <= 1'b0;
        end else begin
            menu <= next_menu;
            hold <= next_hold;
            fired <= next_fired;
            sel_rt <= next_sel_rt;
            wait_cnt <= next_wait;
            O_LOAD_DEFAULTS <= next_defaults;
            O_RESTART <= next_restart;
        end
    end
    // Display item follows the menu state
    always_comb begin
        case (menu)
            MENU_RUN: O_DISPLAY_ITEM = SHOW_RUN;
            MENU_ENTERED: O_DISPLAY_ITEM = SHOW_MENU;
            MENU_CHOICE: O_DISPLAY_ITEM = SHOW_CHOICE;
            default: O_DISPLAY_ITEM = SHOW_PARAM;
        endcase
    end
    assign O_SELECT_RUNTIME = sel_rt;

    // Checks
    property p_duty;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) pin_s2.duty_open && duty_input_enable_param |=> alarms[AL_DUTY];
    endproperty
    a_duty: assert property (p_duty) else $error("duty alarm missed");
    property p_runtime;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) runtime > runtime_threshold_param |=> alarms[AL_RUNTIME];
    endproperty
    a_runtime: assert property (p_runtime) else $error("runtime alarm missed");
    property p_comm_hold;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) alarms[AL_COMM] && !setpoint_ok |=> alarms[AL_COMM];
    endproperty
    a_comm_hold: assert property (p_comm_hold) else $error("comm alarm lost");
    property p_reset_all;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) alarm_reset && (cause & LEVEL2_MASK) == '0
            |=> (alarms & LEVEL2_MASK) == '0;
    endproperty
    a_reset_all: assert property (p_reset_all) else $error("level two alarms not cleared");
    property p_out_en;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) !I_SYS_RST && (alarms & ~LEVEL2_MASK) == '0 |=> O_OUTPUT_ENABLE;
    endproperty
    a_out_en: assert property (p_out_en) else $error("output stopped by level two");
    property p_inhibit;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) alarms[AL_RAM] |=> !O_OUTPUT_ENABLE;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("output not inhibited");
    property p_rt_zero;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) rt_clear |=> runtime == 32'h0 ##1 O_DISPLAY_ITEM == SHOW_PARAM;
    endproperty
    a_rt_zero: assert property (p_rt_zero) else $error("runtime not zeroed");
    property p_tmo_off;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) comm_timeout_param == 16'h0 && !alarms[AL_COMM]
            |=> !alarms[AL_COMM];
    endproperty
    a_tmo_off: assert property (p_tmo_off) else $error("timeout with zero setting");
    property p_restart;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) menu == MENU_LEVEL && long_press |=> O_RESTART && menu == MENU_RUN;
    endproperty
    a_restart: assert property (p_restart) else $error("restart missed");
    property p_ram_latch;
        @(posedge I_REF_CLK) disable iff (I_SYS_RST) alarms[AL_RAM] |=> alarms[AL_RAM];
    endproperty
    a_ram_latch: assert property (p_ram_latch) else $error("ram error not latched");
    c_defaults: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) O_LOAD_DEFAULTS);
    c_restart: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) O_RESTART);
    c_burn: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) alarms[AL_BURN] && O_OUTPUT_ENABLE);
    c_comm_clear: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) alarms[AL_COMM] && setpoint_ok);
endmodule : aem_alarm_manager

// ---- verif/aem_host_model.sv ----
`timescale 1ns/1ps
module aem_host_model (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; setpoint writes and reset commands pass here too
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Request held until pready is seen high at an edge; only the bench watchdog ends a stall
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Released bus must not keep showing old data
    endtask : xfer
endmodule : aem_host_model

// ---- verif/tb_aem_alarm_manager.sv ----
`timescale 1ns/1ps
module tb_aem_alarm_manager import aem_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, pen, pwr, pready, perr, oen, ld, rs, sel;
    logic [7:0] paddr, code;
    logic [31:0] pwd, prd, r;
    logic [1:0] disp;
    logic [2:0] keys = 3'h0; // Enter, level, up
    logic [3:0] fatal = 4'h0; // Ram, system, settings, run-time area
    logic rst_in = 1'b0;
    logic burn = 1'b0;
    logic line = 1'b0;
    logic rng = 1'b0;
    logic duty = 1'b0;
    logic e;
    int err_count = 0;
    int checked = 0;
    int ld_cnt = 0;
    int rs_cnt = 0;
    logic [7:0] fcode [4] = '{ram_fault_code, system_checksum_code, settings_checksum_code, runtime_checksum_code};

    // Clock of 50 ns
    always #25 clk = ~clk;

    aem_alarm_manager #(.LONG_CYC(20), .RETURN_CYC(10), .TICK_CYC(4)) aem_alarm_manager_i (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(pready), .O_PSLVERR(perr),
        .I_ENTER_CLEAR_KEY(keys[0]), .I_LEVEL_SELECT_KEY(keys[1]), .I_UP_KEY(keys[2]),
        .I_RESET_INPUT(rst_in), .I_BURN_EXCEED(burn), .I_LINE_CYCLE(line), .I_RANGE_FAULT(rng),
        .I_DUTY_OPEN(duty), .I_RAM_FAULT(fatal[0]), .I_NV_SYS_BAD(fatal[1]), .I_NV_SET_BAD(fatal[2]),
        .I_NV_RT_BAD(fatal[3]), .O_OUTPUT_ENABLE(oen), .O_ERROR_CODE(code), .O_DISPLAY_ITEM(disp),
        .O_SELECT_RUNTIME(sel), .O_LOAD_DEFAULTS(ld), .O_RESTART(rs));

    aem_host_model aem_host_model_i (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(paddr),
        .pwdata(pwd), .prdata(prd), .pready(pready), .pslverr(perr));

    // Pulses last one cycle, so they are counted at every edge
    always @(posedge clk) begin
        if (ld === 1'b1) ld_cnt++;
        if (rs === 1'b1) rs_cnt++;
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        aem_host_model_i.xfer(1'b1, a, d, r, e);
    endtask : wr

    task rd(input logic [7:0] a);
        aem_host_model_i.xfer(1'b0, a, 32'h0, r, e);
    endtask : rd

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Poll one status bit until it takes the wanted value, bounded
    task poll(input int b, input logic v, input string nm);
        int n;
        n = 0;
        do begin
            rd(OFS_STATUS);
            n++;
        end while (r[b] !== v && n < 40);
        chk(nm, r[b], v);
    endtask : poll

    task key(input int k, input int n);
        keys[k] <= 1'b1;
        cyc(n);
        keys[k] <= 1'b0;
        cyc(8);
    endtask : key

    task do_reset();
        rst <= 1'b1;
        cyc(20);
        rst <= 1'b0;
        cyc(4);
    endtask : do_reset

    task t_fatal();
        for (int i = 0; i < 4; i++) begin
            fatal[i] <= 1'b1;
            poll(i, 1'b1, "fatal_set");
            chk("fatal_code", code, fcode[i]);
            chk("fatal_stop", oen, 1'b0);
            fatal[i] <= 1'b0;
            cyc(8);
            key(0, 2);
            rd(OFS_STATUS);
            chk("fatal_held", r[i], 1'b1);
            do_reset();
            chk("fatal_gone", oen, 1'b1);
        end
    endtask : t_fatal

    task t_level2();
        rng <= 1'b1;
        duty <= 1'b1;
        poll(5, 1'b1, "range_set");
        poll(6, 1'b1, "duty_set");
        chk("lvl2_run", oen, 1'b1);
        rng <= 1'b0;
        duty <= 1'b0;
        cyc(8);
        rd(OFS_STATUS);
        chk("lvl2_held", r[6:5], 2'h3);
        key(0, 2);
        rd(OFS_STATUS);
        chk("key_clear_all", r[6:5], 2'h0);
        rng <= 1'b1;
        poll(5, 1'b1, "range_set2");
        chk("range_code", code, input_range_alarm_code);
        rng <= 1'b0;
        cyc(8);
        rst_in <= 1'b1;
        cyc(3);
        rst_in <= 1'b0;
        cyc(8);
        rd(OFS_STATUS);
        chk("pin_clear", r[5], 1'b0);
        rng <= 1'b1;
        poll(5, 1'b1, "range_set3");
        rng <= 1'b0;
        cyc(8);
        wr(OFS_CTRL, 32'h5);
        rd(OFS_STATUS);
        chk("cmd_refused", r[5], 1'b1);
        wr(OFS_CTRL, 32'h3);
        wr(OFS_CTRL, 32'h7);
        rd(OFS_STATUS);
        chk("cmd_clear", r[5], 1'b0);
        wr(OFS_CTRL, 32'h2);
        duty <= 1'b1;
        cyc(12);
        rd(OFS_STATUS);
        chk("duty_off", r[6], 1'b0);
        duty <= 1'b0;
        wr(OFS_CTRL, 32'h3);
    endtask : t_level2

    task lcyc(input logic v, input int n);
        repeat (n) begin
            burn <= v;
            line <= 1'b1;
            cyc(4);
            line <= 1'b0;
            cyc(4);
        end
    endtask : lcyc

    task t_burn();
        lcyc(1'b1, 3);
        lcyc(1'b0, 1);
        lcyc(1'b1, 3);
        cyc(6);
        rd(OFS_STATUS);
        chk("burn_quiet", r[4], 1'b0);
        lcyc(1'b1, 1);
        poll(4, 1'b1, "burn_set");
        chk("burn_run", oen, 1'b1);
        lcyc(1'b0, 1);
        key(0, 2);
    endtask : t_burn

    task t_menu();
        key(1, 30);
        chk("level_in", disp, SHOW_PARAM);
        key(0, 2);
        chk("menu_in", disp, SHOW_MENU);
        key(2, 2);
        chk("choice", disp, SHOW_CHOICE);
        key(0, 2);
        chk("defaults", ld_cnt, 1);
        cyc(20);
        chk("return", disp, SHOW_PARAM);
        key(0, 2);
        chk("return_menu", disp, SHOW_MENU);
        key(2, 2);
        key(0, 2);
        chk("defaults2", ld_cnt, 2);
        key(1, 30);
        chk("restart", rs_cnt, 1);
        chk("run_disp", disp, SHOW_RUN);
    endtask : t_menu

    task t_runtime();
        wr(OFS_RT_THRESH, 32'h3);
        poll(7, 1'b1, "rt_set");
        chk("rt_run", oen, 1'b1);
        wr(OFS_RT_THRESH, 32'hFFFFFFFF);
        key(1, 30);
        key(2, 2);
        chk("rt_select", sel, 1'b1);
        key(0, 2);
        key(2, 2);
        key(0, 2);
        rd(OFS_RUNTIME);
        chk("rt_zero", r < 32'h9, 1'b1);
        chk("no_defaults", ld_cnt, 2);
        key(1, 30);
        key(0, 2);
        rd(OFS_STATUS);
        chk("rt_clear", r[7], 1'b0);
    endtask : t_runtime

    task t_comm();
        cyc(60);
        rd(OFS_STATUS);
        chk("tmo_off", r[8], 1'b0);
        wr(OFS_COMM_TMO, 32'h2);
        cyc(40);
        rd(OFS_STATUS);
        chk("tmo_set", r[8], 1'b1);
        chk("tmo_stop", oen, 1'b0);
        key(0, 2);
        wr(OFS_SETPOINT, 32'h3E9);
        rd(OFS_STATUS);
        chk("tmo_held", r[8], 1'b1);
        wr(OFS_SETPOINT, 32'h100);
        wr(OFS_COMM_TMO, 32'h0);
        rd(OFS_STATUS);
        chk("tmo_clear", r[8], 1'b0);
        cyc(4);
        chk("tmo_run", oen, 1'b1);
    endtask : t_comm

    task results();
        $display("Checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        cyc(30000);
        err_count++;
        results();
    end

    // Main sequence
    initial begin
        do_reset();
        rd(OFS_CTRL);
        chk("ctrl_rst", r, 32'h1);
        rd(8'h40);
        chk("unmapped", e, 1'b1);
        chk("oen_rst", oen, 1'b1);
        t_fatal();
        t_level2();
        t_burn();
        t_menu();
        t_runtime();
        t_comm();
        results();
    end
endmodule : tb_aem_alarm_manager
